// ===== common/rps_pkg.sv
// Constants, state codes and a helper function for the status and configuration port.
// Assumes a single 50 MHz core clock and an active-low asynchronous reset.
//
// Notes on behaviour
// - Reserved status fields always read as zero.
// - Primary bit 4 reads one, bit 3 unused.
// - Poisoned completion with parity response sets primary 8.
// - Primary bits 11 to 13 never set.
// - Error message with both enables sets primary 14.
// - Upstream error message with enable sets primary 14.
// - Poisoned downstream transmit sets primary 15.
// - Secondary 8: poisoned completion or write, enabled.
// - User completer abort sets secondary 11.
// - Completer-abort completion status sets secondary 12.
// - Unsupported-request completion status sets secondary 13.
// - Any received error message sets secondary 14.
// - Any received poisoned packet sets secondary 15.
// - Read returns addressed register when done strobes.
// - Only read-write bits accept writes.
// - Writes update only enabled bytes.
package rps_pkg;

  // ==========================================================================
  // Register offsets in bytes.
  localparam logic [11:0] CMD_OFS     = 12'h004;
  localparam logic [11:0] PRI_STS_OFS = 12'h006;
  localparam logic [11:0] SEC_STS_OFS = 12'h01E;
  localparam logic [11:0] BRG_CTL_OFS = 12'h03E;

  // ==========================================================================
  // Field positions.
  localparam int CMD_PERR_RESP_BIT = 6;
  localparam int CMD_SERR_EN_BIT   = 8;
  localparam int BRG_PERR_RESP_BIT = 0;
  localparam int BRG_SERR_EN_BIT   = 1;
  localparam int STS_CAP_LIST_BIT  = 4;
  localparam int STS_MDPE_BIT      = 8;
  localparam int STS_STA_BIT       = 11;
  localparam int STS_RTA_BIT       = 12;
  localparam int STS_RMA_BIT       = 13;
  localparam int STS_SSE_BIT       = 14;
  localparam int STS_DPE_BIT       = 15;

  // ==========================================================================
  // Masks, reset values and completion status codes.
  localparam logic [15:0] CMD_RW_MASK   = 16'h0547;
  localparam logic [15:0] BRG_RW_MASK   = 16'h0003;
  localparam logic [15:0] PRI_W1C_MASK  = 16'hF900;
  localparam logic [15:0] SEC_W1C_MASK  = 16'hF900;
  localparam logic [15:0] CMD_RESET     = 16'h0000;
  localparam logic [15:0] BRG_RESET     = 16'h0000;
  localparam logic [15:0] STS_RESET     = 16'h0000;
  localparam logic [2:0]  CPL_STS_UR    = 3'h1;
  localparam logic [2:0]  CPL_STS_CA    = 3'h4;

  // ==========================================================================
  // Access sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } rps_state_t;

  // Expands two byte enables to a 16-bit mask.
  function automatic logic [15:0] rps_lane_mask(input logic [1:0] be);
    rps_lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage

// ===== common/rps_flag_if.sv
// Interface carrying set and clear vectors to a bank of sticky flags.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface rps_flag_if #(
  parameter int W = 16
);
  logic [W-1:0] setVec;
  logic [W-1:0] clrVec;
  logic [W-1:0] flags;

  modport owner (
    input  setVec,
    input  clrVec,
    output flags
  );

  modport user (
    output setVec,
    output clrVec,
    input  flags
  );
endinterface

// ===== verilog/rps_sticky_bank.sv
// Bank of sticky flags set by hardware events and cleared by writes.
// Assumes set and clear vectors come from logic on the same clock.
`timescale 1ns/1ps
module rps_sticky_bank
  import rps_pkg::*;
#(
  parameter int W = 16
) (
  // Clock, reset and enable.
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // Flag vectors.
  rps_flag_if.owner fl
);

  logic [W-1:0] flags_reg;

  // ==========================================================================
  // Flag storage.
  // Set wins over clear when both land in the same cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= W'(STS_RESET);
    end else if (clkEn) begin
      flags_reg <= (flags_reg & ~fl.clrVec) | fl.setVec;
    end
  end

  assign fl.flags = flags_reg;

endmodule

// ===== verilog/rps_cfg_port.sv
// Root port status registers and configuration management port.
// Assumes all event inputs are single-cycle pulses on the core clock.
`timescale 1ns/1ps
module rps_cfg_port
  import rps_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        clkEn,
  // Management port.
  input  wire logic [9:0]  mgmtDwAddr,
  input  wire logic [31:0] mgmt_write_data,
  input  wire logic [3:0]  mgmtByteEn,
  input  wire logic        mgmtRdReq,
  input  wire logic        mgmtWrReq,
  output logic      [31:0] mgmtReadData,
  output logic             mgmtAccessDone,
  // Received completions.
  input  wire logic        rxCplValid,
  input  wire logic        rxCplPoisoned,
  input  wire logic [2:0]  rxCplStatus,
  // Any received packet.
  input  wire logic        rxPktValid,
  input  wire logic        rxPktPoisoned,
  // Received fatal or non-fatal error message.
  input  wire logic        rxErrMsg,
  // Transmitted downstream packets.
  input  wire logic        txPktValid,
  input  wire logic        txPktPoisoned,
  input  wire logic        txPktIsWrite,
  // Message output and user error report.
  input  wire logic        msgErrUpstream,
  input  wire logic        usrCplAbort,
  // Control bits seen by the rest of the core.
  output logic             parityErrRespEn,
  output logic             system_error_enable,
  output logic             secParityErrRespEn,
  output logic             secSystemErrorEnable
);

  // ==========================================================================
  // Dword addresses of the mapped words.
  localparam logic [9:0] CMD_DW = CMD_OFS[11:2];
  localparam logic [9:0] SEC_DW = SEC_STS_OFS[11:2];
  localparam logic [9:0] BRG_DW = BRG_CTL_OFS[11:2];

  // ==========================================================================
  // Declarations.
  rps_state_t  state_reg;
  rps_state_t  state_next;
  logic [9:0]  addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  be_reg;
  logic        isWrite_reg;
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic [15:0] brg_reg;
  logic [15:0] brg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        done_reg;
  logic        execWrite;
  logic [15:0] upperMask;
  logic [15:0] lowerMask;
  logic [15:0] priReadVal;
  logic [15:0] secReadVal;
  logic        rxCplPoison;
  logic        rxPoisonAny;
  logic        txPoisonWrite;

  rps_flag_if #(.W(16)) priIf ();
  rps_flag_if #(.W(16)) secIf ();

  // ==========================================================================
  // Sticky status banks.
  rps_sticky_bank #(
    .W(16)
  ) u_pri (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clkEn    (clkEn),
    .fl       (priIf)
  );

  rps_sticky_bank #(
    .W(16)
  ) u_sec (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clkEn    (clkEn),
    .fl       (secIf)
  );

  // ==========================================================================
  // Access sequencer.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (mgmtRdReq || mgmtWrReq) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Request capture.
  // Address, data and enables are held for the whole access.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg    <= '0;
      wdata_reg   <= '0;
      be_reg      <= '0;
      isWrite_reg <= 1'b0;
    end else if (clkEn && state_reg == ST_IDLE && (mgmtRdReq || mgmtWrReq)) begin
      addr_reg    <= mgmtDwAddr;
      wdata_reg   <= mgmt_write_data;
      be_reg      <= mgmtByteEn;
      isWrite_reg <= mgmtWrReq;
    end
  end

  assign execWrite = (state_reg == ST_EXEC) && isWrite_reg;
  assign lowerMask = rps_lane_mask(be_reg[1:0]);
  assign upperMask = rps_lane_mask(be_reg[3:2]);

  // ==========================================================================
  // Writable control registers.
  // Only read-write bits in enabled byte lanes take the new value.
  always_comb begin
    cmd_next = cmd_reg;
    brg_next = brg_reg;
    if (execWrite && addr_reg == CMD_DW) begin
      cmd_next = (cmd_reg & ~(CMD_RW_MASK & lowerMask))
               | (wdata_reg[15:0] & CMD_RW_MASK & lowerMask);
    end
    if (execWrite && addr_reg == BRG_DW) begin
      brg_next = (brg_reg & ~(BRG_RW_MASK & upperMask))
               | (wdata_reg[31:16] & BRG_RW_MASK & upperMask);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_reg <= CMD_RESET;
      brg_reg <= BRG_RESET;
    end else if (clkEn) begin
      cmd_reg <= cmd_next;
      brg_reg <= brg_next;
    end
  end

  assign parityErrRespEn      = cmd_reg[CMD_PERR_RESP_BIT];
  assign system_error_enable  = cmd_reg[CMD_SERR_EN_BIT];
  assign secParityErrRespEn   = brg_reg[BRG_PERR_RESP_BIT];
  assign secSystemErrorEnable = brg_reg[BRG_SERR_EN_BIT];

  // ==========================================================================
  // Write-one-to-clear requests to the status banks.
  always_comb begin
    priIf.clrVec = '0;
    secIf.clrVec = '0;
    if (execWrite && addr_reg == CMD_DW) begin
      priIf.clrVec = wdata_reg[31:16] & upperMask & PRI_W1C_MASK;
    end
    if (execWrite && addr_reg == SEC_DW) begin
      secIf.clrVec = wdata_reg[31:16] & upperMask & SEC_W1C_MASK;
    end
  end

  // ==========================================================================
  // Event decode.
  assign rxCplPoison   = rxCplValid && rxCplPoisoned;
  assign rxPoisonAny   = (rxPktValid && rxPktPoisoned) || rxCplPoison;
  assign txPoisonWrite = txPktValid && txPktPoisoned && txPktIsWrite;

  // Primary status events.
  always_comb begin
    priIf.setVec = '0;
    priIf.setVec[STS_MDPE_BIT] = parityErrRespEn && rxCplPoison;
    priIf.setVec[STS_STA_BIT]  = 1'b0;
    priIf.setVec[STS_RTA_BIT]  = 1'b0;
    priIf.setVec[STS_RMA_BIT]  = 1'b0;
    priIf.setVec[STS_SSE_BIT]  =
      (rxErrMsg && system_error_enable && secSystemErrorEnable)
      || (msgErrUpstream && system_error_enable);
    priIf.setVec[STS_DPE_BIT]  = txPktValid && txPktPoisoned;
  end

  // Secondary status events.
  always_comb begin
    secIf.setVec = '0;
    secIf.setVec[STS_MDPE_BIT] =
      secParityErrRespEn && (rxCplPoison || txPoisonWrite);
    secIf.setVec[STS_STA_BIT]  = usrCplAbort;
    secIf.setVec[STS_RTA_BIT]  = rxCplValid && rxCplStatus == CPL_STS_CA;
    secIf.setVec[STS_RMA_BIT]  = rxCplValid && rxCplStatus == CPL_STS_UR;
    secIf.setVec[STS_SSE_BIT]  = rxErrMsg;
    secIf.setVec[STS_DPE_BIT]  = rxPoisonAny;
  end

  // ==========================================================================
  // Read values.
  // Reserved fields are masked off and the capability bit is tied high.
  always_comb begin
    priReadVal = priIf.flags & PRI_W1C_MASK;
    priReadVal[STS_CAP_LIST_BIT] = 1'b1;
    secReadVal = secIf.flags & SEC_W1C_MASK;
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (state_reg == ST_EXEC) begin
      unique case (addr_reg)
        CMD_DW:  rdata_next = {priReadVal, cmd_reg};
        SEC_DW:  rdata_next = {secReadVal, 16'h0000};
        BRG_DW:  rdata_next = {brg_reg, 16'h0000};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Answer registers.
  // Data and done appear together one cycle after the access executes.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= '0;
      done_reg  <= 1'b0;
    end else if (clkEn) begin
      rdata_reg <= rdata_next;
      done_reg  <= (state_reg == ST_EXEC);
    end
  end

  assign mgmtReadData   = rdata_reg;
  assign mgmtAccessDone = done_reg;

endmodule

// ===== tb/rps_cfg_port_monitor.sv
// Concurrent checks on the ports of the status and configuration port.
// Assumes clkEn stays high and requests keep the documented spacing.
`timescale 1ns/1ps
module rps_cfg_port_monitor
  import rps_pkg::*;
(
  // Clock, reset and enable.
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        clkEn,
  // Management port.
  input wire logic [9:0]  mgmtDwAddr,
  input wire logic [31:0] mgmt_write_data,
  input wire logic [3:0]  mgmtByteEn,
  input wire logic        mgmtRdReq,
  input wire logic        mgmtWrReq,
  input wire logic [31:0] mgmtReadData,
  input wire logic        mgmtAccessDone,
  // Control outputs.
  input wire logic        parityErrRespEn,
  input wire logic        system_error_enable,
  input wire logic        secParityErrRespEn,
  input wire logic        secSystemErrorEnable
);
  // ====================
  // Tracks when the port is idle and takes a request.
  logic [1:0] bsyCnt;
  logic       taken;
  assign taken = clkEn && bsyCnt == 2'h0 && (mgmtRdReq || mgmtWrReq);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) bsyCnt <= 2'h0;
    else if (taken) bsyCnt <= 2'h2;
    else if (clkEn && bsyCnt != 2'h0) bsyCnt <= bsyCnt - 2'h1;
  end

  // ====================
  // Checks.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_answer;
    !mgmtAccessDone ##1 mgmtAccessDone ##1 !mgmtAccessDone;
  endsequence
  a_done_timing: assert property (taken |=> s_answer)
    else $error("done pulse late or missing");
  a_done_cause: assert property (mgmtAccessDone |-> $past(taken, 2))
    else $error("done pulse without request");
  a_pri_fixed: assert property (mgmtAccessDone && mgmtDwAddr == 10'h001 |->
    (mgmtReadData[31:16] & 16'h3EFF) == 16'h0010) else $error("primary fixed bits wrong");
  a_sec_reserved: assert property (mgmtAccessDone && mgmtDwAddr == 10'h007 |->
    (mgmtReadData & 32'h06FFFFFF) == 32'h0) else $error("secondary reserved bits set");
  a_serr_write: assert property ($changed(system_error_enable) |-> mgmtAccessDone &&
    $past(mgmtWrReq && mgmtByteEn[1] && mgmtDwAddr == 10'h001, 2) &&
    system_error_enable == $past(mgmt_write_data[8], 2)) else $error("bad enable change");
  a_perr_write: assert property ($changed(parityErrRespEn) |-> mgmtAccessDone &&
    $past(mgmtWrReq && mgmtByteEn[0] && mgmtDwAddr == 10'h001, 2) &&
    parityErrRespEn == $past(mgmt_write_data[6], 2)) else $error("bad parity enable change");
  a_brg_write: assert property ($changed({secSystemErrorEnable, secParityErrRespEn}) |->
    mgmtAccessDone && $past(mgmtWrReq && mgmtByteEn[2] && mgmtDwAddr == 10'h00F, 2))
    else $error("bad bridge control change");
  a_rdata_hold: assert property ($changed(mgmtReadData) |-> mgmtAccessDone)
    else $error("read data moved without done");
endmodule

bind rps_cfg_port rps_cfg_port_monitor mon (.core_clk, .nrst, .clkEn, .mgmtDwAddr,
  .mgmt_write_data, .mgmtByteEn, .mgmtRdReq, .mgmtWrReq, .mgmtReadData, .mgmtAccessDone,
  .parityErrRespEn, .system_error_enable, .secParityErrRespEn, .secSystemErrorEnable);

// ===== tb/rps_user_model.sv
// Behavioural user logic that drives the management port.
// Assumes a registered one-cycle done pulse from the port.
`timescale 1ns/1ps
module rps_user_model (
  // Clock and answer.
  input  wire logic        core_clk,
  input  wire logic        mgmtAccessDone,
  input  wire logic [31:0] mgmtReadData,
  // Request.
  output logic      [9:0]  mgmtDwAddr,
  output logic      [31:0] mgmt_write_data,
  output logic      [3:0]  mgmtByteEn,
  output logic             mgmtRdReq,
  output logic             mgmtWrReq
);
  initial begin
    mgmtDwAddr = 10'h000;
    mgmt_write_data = 32'h0;
    mgmtByteEn = 4'h0;
    mgmtRdReq = 1'b0;
    mgmtWrReq = 1'b0;
  end
  // ====================
  // One access after a random pause, address and data held until done.
  task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    repeat (1 + $urandom_range(2, 0)) @(posedge core_clk);
    mgmtDwAddr <= a;
    mgmt_write_data <= d;
    mgmtByteEn <= be;
    mgmtRdReq <= !wr;
    mgmtWrReq <= wr;
    @(posedge core_clk);
    mgmtRdReq <= 1'b0;
    mgmtWrReq <= 1'b0;
    while (mgmtAccessDone !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    q = mgmtReadData;
    mgmtDwAddr <= ~a;
    mgmt_write_data <= ~d;
  endtask
endmodule

// ===== tb/rootport_status_and_cfg_port_tb_top.sv
// Self-checking bench for the status registers and management port.
// Assumes the checker is bound to the port and the user model drives it.
`timescale 1ns/1ps
module rootport_status_and_cfg_port_tb_top;
  import rps_pkg::*;
  logic        core_clk, nrst, clkEn, rxCplValid, rxCplPoisoned, rxPktValid, rxPktPoisoned;
  logic        rxErrMsg, txPktValid, txPktPoisoned, txPktIsWrite, msgErrUpstream, usrCplAbort;
  logic [2:0]  rxCplStatus;
  logic [9:0]  mgmtDwAddr;
  logic [31:0] mgmt_write_data, mgmtReadData;
  logic [3:0]  mgmtByteEn;
  logic        mgmtRdReq, mgmtWrReq, mgmtAccessDone, parityErrRespEn, system_error_enable;
  logic        secParityErrRespEn, secSystemErrorEnable;
  logic [15:0] cmd, brg, pri, sec;
  int          mismatches, check_count;

  rps_cfg_port uut (.*);
  rps_user_model um (.*);

  // ====================
  // Checking and closing.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] rdExp(input logic [9:0] a);
    case (a)
      10'h001: rdExp = {pri | 16'h0010, cmd};
      10'h007: rdExp = {sec, 16'h0000};
      10'h00F: rdExp = {brg, 16'h0000};
      default: rdExp = 32'h0;
    endcase
  endfunction

  // ====================
  // Access and model update.
  task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    logic [31:0] q, m;
    um.acc(wr, a, d, be, q);
    chk(q, rdExp(a));
    for (int i = 0; i < 4; i++) m[8*i+:8] = {8{be[i] & wr}};
    d = d & m;
    if (a == 10'h001) cmd = (cmd & ~(m[15:0] & CMD_RW_MASK)) | (d[15:0] & CMD_RW_MASK);
    if (a == 10'h001) pri = pri & ~d[31:16];
    if (a == 10'h007) sec = sec & ~d[31:16];
    if (a == 10'h00F) brg = (brg & ~(m[31:16] & BRG_RW_MASK)) | (d[31:16] & BRG_RW_MASK);
    m = {28'h0, brg[1:0], cmd[8], cmd[6]};
    chk({28'h0, secSystemErrorEnable, secParityErrRespEn, system_error_enable, parityErrRespEn}, m);
  endtask
  task automatic ev(input int k);
    @(posedge core_clk);
    rxCplValid <= k < 3;
    rxCplPoisoned <= k == 0;
    rxCplStatus <= (k == 1) ? CPL_STS_UR : (k == 2) ? CPL_STS_CA : 3'h0;
    rxPktValid <= k == 3;
    rxPktPoisoned <= k == 3;
    rxErrMsg <= k == 4;
    txPktValid <= k == 5 || k == 6;
    txPktPoisoned <= k == 5 || k == 6;
    txPktIsWrite <= k == 5;
    msgErrUpstream <= k == 7;
    usrCplAbort <= k == 8;
    @(posedge core_clk);
    {rxCplValid, rxCplPoisoned, rxCplStatus, rxPktValid, rxPktPoisoned, rxErrMsg, txPktValid,
     txPktPoisoned, txPktIsWrite, msgErrUpstream, usrCplAbort} <= '0;
    pri[8] = pri[8] | (k == 0 && cmd[6]);
    pri[14] = pri[14] | (k == 4 && cmd[8] && brg[1]) | (k == 7 && cmd[8]);
    pri[15] = pri[15] | k == 5 | k == 6;
    sec[8] = sec[8] | (brg[0] && (k == 0 || k == 5));
    sec[11] = sec[11] | k == 8;
    sec[12] = sec[12] | k == 2;
    sec[13] = sec[13] | k == 1;
    sec[14] = sec[14] | k == 4;
    sec[15] = sec[15] | k == 0 | k == 3;
  endtask
  task automatic rst();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    {cmd, brg, pri, sec} = '0;
  endtask

  // ====================
  // Clock, watchdog and tests.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  initial begin
    void'($urandom(5));
    nrst = 1'b0;
    clkEn = 1'b1;
    {rxCplValid, rxCplPoisoned, rxCplStatus, rxPktValid, rxPktPoisoned, rxErrMsg, txPktValid,
     txPktPoisoned, txPktIsWrite, msgErrUpstream, usrCplAbort} = '0;
    rst();
    for (int a = 0; a < 16; a++) acc(1'b0, 10'(a), 32'h0, 4'h0);
    for (int i = 0; i < 45; i++) begin
      acc(1'b1, 10'h001, $urandom, 4'($urandom));
      acc(1'b1, 10'h00F, $urandom, 4'($urandom));
      ev(i % 9);
      ev($urandom_range(8, 0));
      acc(1'b0, 10'h007, $urandom, 4'($urandom));
      acc(1'b1, 10'($urandom_range(15, 0)), $urandom, 4'($urandom));
    end
    acc(1'b1, 10'h007, 32'hFFFF_FFFF, 4'hF);
    @(posedge core_clk);
    clkEn <= 1'b0;
    rxErrMsg <= 1'b1;
    @(posedge core_clk);
    rxErrMsg <= 1'b0;
    @(posedge core_clk);
    clkEn <= 1'b1;
    acc(1'b0, 10'h007, 32'h0, 4'h0);
    rst();
    acc(1'b0, 10'h001, 32'h0, 4'h0);
    summarize();
  end
endmodule
